// ===== bench/host_mem_model.sv
// far-side model: bus arbiter grant and memory target acceptance
`timescale 1ns/1ps
module host_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // stall control from the bench
  input wire logic slow,
  // bus master port of the engine
  input wire logic bm_req,
  output logic bm_gnt,
  input wire logic bm_valid,
  output logic bm_ready
);
  // grant held while request stands; slow mode delays grant and stalls target
  // arbitration and back-pressure
  always @(posedge mclk) begin
    if (srst) begin
      bm_gnt <= 1'b0;
      bm_ready <= 1'b0;
    end else begin
      bm_gnt <= bm_req && (bm_gnt || !slow || $urandom_range(3) == 0);
      // slow target stalls only words on offer; idle ready is free
      bm_ready <= !slow || !bm_valid || $urandom_range(2) != 0;
    end
  end
endmodule

// ===== bench/test_parallel_dio_busmaster_dma.sv
// self-checking bench for the digital i/o block transfer engine
`timescale 1ns/1ps
module test_parallel_dio_busmaster_dma;
  import dio_pkg::*;
  logic mclk, srst, out_word_wr, out_bit_wr, out_bit_data, trig_req_pin, start, stop;
  logic [31:0] din_pins, input_word, out_word_data, dout_pins, dest_addr, bm_addr, bm_data;
  logic [4:0] input_bit_index, output_bit_index;
  logic input_bit_value, trig_ack_pin, clear_fifo_on_start, halt_sampling_on_done;
  logic double_buf, irq_enable, transfer_active, done_irq, overrun;
  logic bm_req, bm_gnt, bm_valid, bm_ready, slow, irqen, paced, sampling;
  sample_mode_e sample_mode;
  logic [15:0] pacer_div;
  logic [26:0] byte_count;
  logic [24:0] words_done;
  logic [31:0] exp_q[$]; // words the bench expects on the bus, in order
  logic [31:0] d, dout_m, base, paced_word;
  int error_cnt, checked, acc, irqs, cyc, nwords, k;
  int unsigned seed;

  dio_dma dut (.mclk(mclk), .srst(srst), .din_pins(din_pins),
    .input_bit_index(input_bit_index), .input_word(input_word),
    .input_bit_value(input_bit_value), .out_word_wr(out_word_wr),
    .out_word_data(out_word_data), .out_bit_wr(out_bit_wr),
    .output_bit_index(output_bit_index), .out_bit_data(out_bit_data),
    .dout_pins(dout_pins), .sample_mode(sample_mode), .pacer_div(pacer_div),
    .trig_req_pin(trig_req_pin), .trig_ack_pin(trig_ack_pin), .start(start), .stop(stop),
    .dest_addr(dest_addr), .byte_count(byte_count),
    .clear_fifo_on_start(clear_fifo_on_start),
    .halt_sampling_on_done(halt_sampling_on_done), .double_buf(double_buf),
    .irq_enable(irq_enable), .transfer_active(transfer_active), .words_done(words_done),
    .done_irq(done_irq), .overrun(overrun), .bm_req(bm_req), .bm_gnt(bm_gnt),
    .bm_addr(bm_addr), .bm_data(bm_data), .bm_valid(bm_valid), .bm_ready(bm_ready));

  host_mem_model host (.mclk(mclk), .srst(srst), .slow(slow), .bm_req(bm_req),
    .bm_gnt(bm_gnt), .bm_valid(bm_valid), .bm_ready(bm_ready));

  // free-running clock, 40 ns period
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one comparison, four-state exact
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask

  // bus monitor: every accepted word against the model; also a hang guard
  always @(posedge mclk) begin
    cyc++;
    if (!srst && done_irq === 1'b1) irqs++;
    if (!srst && bm_valid === 1'b1 && bm_ready === 1'b1) begin
      chk("bm_addr", base + 32'(4 * (acc % nwords)), bm_addr);
      chk("bm_data", paced ? paced_word : exp_q.pop_front(), bm_data);
      acc++;
    end
    // hang guard last, so nothing follows the closing report
    if (cyc > 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // start a block; low count bits set on purpose, they must be ignored
  task automatic go(sample_mode_e m, int n, bit clr, bit halt, bit db);
    tick(1);
    base = $urandom() & 32'hFFFF_FFFC;
    irqen = 1'($urandom_range(1));
    nwords = n;
    acc = 0;
    irqs = 0;
    if (clr) exp_q.delete();
    dest_addr <= base;
    byte_count <= 27'(4 * n + 3);
    sample_mode <= m;
    trig_req_pin <= (m == sample_mode_fall);
    clear_fifo_on_start <= clr;
    halt_sampling_on_done <= halt;
    double_buf <= db;
    irq_enable <= irqen;
    slow <= 1'($urandom_range(1));
    // mode and idle pin level settle through the synchroniser before start
    tick(4);
    start <= 1'b1;
    sampling = 1;
    tick(1);
    start <= 1'b0;
    #1;
    chk("transfer_active", 1, 32'(transfer_active));
    chk("overrun at start", 0, 32'(overrun));
  endtask

  // bounded wait for completion, then settle
  task automatic wait_idle(int lim);
    k = 0;
    while (transfer_active !== 1'b0 && k < lim) begin
      tick(1);
      k++;
    end
    tick(3);
    chk("transfer_active", 0, 32'(transfer_active));
  endtask

  // present a word, then fire the trigger of the current mode
  task automatic sample(logic [31:0] w);
    din_pins <= w;
    tick(5);
    if (sampling) exp_q.push_back(w);
    trig_req_pin <= (sample_mode != sample_mode_fall);
    if (sample_mode == sample_mode_handshake) begin
      for (k = 0; k < 20 && trig_ack_pin !== 1'b1; k++) begin
        tick(1);
        #1;
      end
      chk("trig_ack_pin", 1, 32'(trig_ack_pin));
    end
    tick(4);
    trig_req_pin <= (sample_mode == sample_mode_fall);
    tick(6);
  endtask

  initial begin
    {srst, out_word_wr, out_bit_wr, out_bit_data, trig_req_pin, start, stop} = 7'h40;
    {din_pins, out_word_data, dest_addr, input_bit_index, output_bit_index} = '0;
    {clear_fifo_on_start, halt_sampling_on_done, double_buf, irq_enable, slow} = '0;
    {paced, sampling, paced_word, base} = '0;
    sample_mode = sample_mode_pacer;
    pacer_div = 16'h0003;
    byte_count = '0;
    nwords = 1;
    seed = $urandom(32'h9137);
    tick(6);
    srst <= 1'b0;
    tick(1);
    #1;
    chk("reset dout_pins", 0, dout_pins);
    chk("reset words_done", 0, 32'(words_done));
    chk("reset bm_req", 0, 32'(bm_req));
    // polled input word and bit, output word and bit, index ends included
    for (int i = 0; i < 8; i++) begin
      tick(1);
      d = $urandom();
      k = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(31);
      din_pins <= d;
      input_bit_index <= 5'(k);
      tick(5);
      #1;
      chk("input_word", d, input_word);
      chk("input_bit_value", 32'(d[k]), 32'(input_bit_value));
      tick(1);
      dout_m = $urandom();
      out_word_wr <= 1'b1;
      out_word_data <= dout_m;
      out_bit_wr <= 1'b1;
      output_bit_index <= 5'(k);
      out_bit_data <= ~dout_m[k];
      tick(1);
      out_word_wr <= 1'b0;
      output_bit_index <= ~5'(k);
      out_bit_data <= ~dout_m[~5'(k)];
      dout_m[~5'(k)] = ~dout_m[~5'(k)];
      tick(1);
      out_bit_wr <= 1'b0;
      tick(1);
      #1;
      chk("dout_pins", dout_m, dout_pins);
    end
    $display("test polled ports done");
    // paced single block, then paced circular block stopped mid-run
    paced_word = $urandom();
    paced = 1;
    tick(1);
    din_pins <= paced_word;
    tick(5);
    go(sample_mode_pacer, 5, 1, 1, 0);
    wait_idle(800);
    chk("words_done", 5, 32'(words_done));
    chk("bus words", 5, 32'(acc));
    chk("irq pulses", 32'(irqen), 32'(irqs));
    go(sample_mode_pacer, 2, 1, 1, 1);
    for (k = 0; k < 800 && acc < 5; k++)
      tick(1);
    chk("wrapped words before stop", 1, 32'(acc >= 5));
    stop <= 1'b1;
    tick(1);
    stop <= 1'b0;
    wait_idle(100);
    tick(4);
    #1;
    chk("words_done after stop", 32'(acc), 32'(words_done));
    chk("bm_req after stop", 0, 32'(bm_req));
    // halt off: sampling runs on after done and overfills the buffer
    go(sample_mode_pacer, 1, 1, 0, 0);
    wait_idle(100);
    tick(12);
    chk("words_done", 1, 32'(words_done));
    chk("irq pulses", 32'(irqen), 32'(irqs));
    chk("overrun after done", 1, 32'(overrun));
    paced = 0;
    $display("test paced blocks done");
    // each edge or handshake mode, three words
    for (int m = 1; m < 4; m++) begin
      go(sample_mode_e'(m), 3, 1, 1, 0);
      tick(3);
      repeat (3) sample($urandom());
      wait_idle(300);
      sampling = 0;
      chk("words_done", 3, 32'(words_done));
      chk("irq pulses", 32'(irqen), 32'(irqs));
      chk("overrun", 0, 32'(overrun));
      $display("test trigger mode %0d done", m);
    end
    // leftover word kept without clearing, dropped with clearing
    go(sample_mode_rise, 1, 1, 0, 0);
    tick(3);
    sample($urandom());
    sample($urandom());
    wait_idle(300);
    go(sample_mode_rise, 1, 0, 0, 0);
    wait_idle(300);
    chk("kept word moved", 1, 32'(acc));
    sample($urandom());
    go(sample_mode_rise, 1, 1, 0, 0);
    tick(3);
    sample($urandom());
    wait_idle(300);
    chk("words after clear", 1, 32'(acc));
    chk("model queue empty", 0, 32'(exp_q.size()));
    stop <= 1'b1;
    tick(1);
    stop <= 1'b0;
    tick(3);
    $display("test start clearing done");
    print_verdict();
  end
endmodule

// ===== inc/dio_params.svh
// constants for the parallel digital i/o block transfer engine
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH
`define DIO_WIDTH 32
`define DIO_IDX_W 5
`define DIO_BYTES_W 27
`define DIO_WORDS_W 25
`define DIO_WORD_BYTES 32'h0000_0004
`define DIO_PACER_W 16
`define DIO_PACER_RST 16'h0000
`define DIO_BUF_DEPTH 2
`endif

// ===== inc/dio_pkg.sv
// types shared by the digital i/o engine and its word buffer
package dio_pkg;
  // sampling sources, in selector order 0..3
  typedef enum logic [1:0] {
    sample_mode_pacer,
    sample_mode_rise,
    sample_mode_fall,
    sample_mode_handshake
  } sample_mode_e;
  // bus master sequencer states
  typedef enum logic [1:0] {
    bm_idle,
    bm_request,
    bm_move
  } bm_state_e;
  typedef logic [31:0] word_t;
endpackage

// ===== inc/word_buf_if.sv
// valid/ready carrier between the sampler, the word buffer and the bus master
`timescale 1ns/1ps
interface word_buf_if;
  logic push_valid;
  logic push_ready;
  logic [31:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [31:0] pop_data;
  logic flush;
  modport buf_mp (input push_valid, push_data, pop_ready, flush,
                  output push_ready, pop_valid, pop_data);
  modport user_mp (output push_valid, push_data, pop_ready, flush,
                   input push_ready, pop_valid, pop_data);
endinterface

// ===== logic/dio_dma.sv
// 32-bit digital i/o with paced input sampling and bus-master block transfer
`timescale 1ns/1ps
`include "dio_params.svh"
module dio_dma (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // input port pins and polled reads
  input wire logic [31:0] din_pins,
  input wire logic [4:0] input_bit_index,
  output logic [31:0] input_word,
  output logic input_bit_value,
  // output port writes
  input wire logic out_word_wr,
  input wire logic [31:0] out_word_data,
  input wire logic out_bit_wr,
  input wire logic [4:0] output_bit_index,
  input wire logic out_bit_data,
  output logic [31:0] dout_pins,
  // sampling control
  input wire dio_pkg::sample_mode_e sample_mode,
  input wire logic [15:0] pacer_div,
  input wire logic trig_req_pin,
  output logic trig_ack_pin,
  // transfer control
  input wire logic start,
  input wire logic stop,
  input wire logic [31:0] dest_addr,
  input wire logic [26:0] byte_count,
  input wire logic clear_fifo_on_start,
  input wire logic halt_sampling_on_done,
  input wire logic double_buf,
  input wire logic irq_enable,
  // transfer status
  output logic transfer_active,
  output logic [24:0] words_done,
  output logic done_irq,
  output logic overrun,
  // bus master side
  output logic bm_req,
  input wire logic bm_gnt,
  output logic [31:0] bm_addr,
  output logic [31:0] bm_data,
  output logic bm_valid,
  input wire logic bm_ready
);
  import dio_pkg::*;
  word_buf_if wb ();
  word_buf u_buf (.mclk(mclk), .srst(srst), .wb(wb));

  // pin synchronisers; only stage two and later are read
  logic [31:0] din_s1_reg, din_s2_reg;
  logic req_s1_reg, req_s2_reg, req_s3_reg;
  // polled port state
  logic [31:0] din_word_reg, din_word_next;
  logic in_bit_reg, in_bit_next;
  logic [31:0] dout_reg, dout_next;
  // sampler state
  logic [15:0] pacer_reg, pacer_next;
  logic ack_reg, ack_next;
  logic sample_en_reg, sample_en_next;
  logic overrun_reg, overrun_next;
  logic tick;
  // engine state
  bm_state_e state_reg, state_next;
  logic active_reg, active_next;
  logic stop_pend_reg, stop_pend_next;
  logic [31:0] base_reg, base_next;
  logic [31:0] addr_reg, addr_next;
  logic [24:0] reload_reg, reload_next;
  logic [24:0] remain_reg, remain_next;
  logic [24:0] words_reg, words_next;
  logic irq_reg, irq_next;
  logic req_reg, req_next;
  logic valid_reg, valid_next;
  logic [31:0] data_reg, data_next;
  logic begin_xfer, last_word;

  // two flops on every pin before use
  always_ff @(posedge mclk) begin
    din_s1_reg <= din_pins;
    din_s2_reg <= din_s1_reg;
    req_s1_reg <= trig_req_pin;
    req_s2_reg <= req_s1_reg;
    req_s3_reg <= req_s2_reg;
  end

  // polled reads and output writes
  always_comb begin
    din_word_next = din_s2_reg;
    // one bit of the same sample
    in_bit_next = din_s2_reg[input_bit_index];
    dout_next = dout_reg;
    // word write drives all lines; it wins over a bit write
    if (out_word_wr) begin
      dout_next = out_word_data;
    end else if (out_bit_wr) begin
      dout_next[output_bit_index] = out_bit_data;
    end
  end

  // sample tick by mode
  always_comb begin
    // four sources; enum order gives codes 0..3
    case (sample_mode)
      sample_mode_pacer: tick = (pacer_reg == `DIO_PACER_RST);
      sample_mode_rise: tick = req_s2_reg & ~req_s3_reg;
      sample_mode_fall: tick = ~req_s2_reg & req_s3_reg;
      // handshake waits for room, so no word is ever dropped there
      sample_mode_handshake: tick = req_s2_reg & ~ack_reg & wb.push_ready;
      default: tick = 1'b0;
    endcase
  end

  // sampler next state
  always_comb begin
    begin_xfer = start & ~active_reg;
    pacer_next = (pacer_reg == `DIO_PACER_RST) ? pacer_div : pacer_reg - 16'h0001;
    ack_next = 1'b0;
    if (sample_mode == sample_mode_handshake) begin
      // ack held until the request drops
      ack_next = ack_reg ? req_s2_reg : (tick & sample_en_reg);
    end
    sample_en_next = sample_en_reg;
    overrun_next = overrun_reg;
    // each captured word is offered to the buffer
    wb.push_valid = sample_en_reg & tick;
    wb.push_data = din_s2_reg;
    // paced modes cannot wait: a full buffer loses the sample, flagged
    if (wb.push_valid & ~wb.push_ready) begin
      overrun_next = 1'b1;
    end
    wb.flush = begin_xfer & clear_fifo_on_start;
    if (begin_xfer) begin
      sample_en_next = 1'b1;
      // start clears the flag, but a sample lost in this very cycle still shows
      overrun_next = wb.push_valid & ~wb.push_ready;
      pacer_next = pacer_div;
    end else if (stop) begin
      // sampling halts at once; buffered words stay intact
      sample_en_next = 1'b0;
    end else if (active_reg & ~active_next & halt_sampling_on_done) begin
      sample_en_next = 1'b0;
    end
  end

  // engine next state
  always_comb begin
    state_next = state_reg;
    active_next = active_reg;
    stop_pend_next = stop_pend_reg | (stop & active_reg);
    base_next = base_reg;
    addr_next = addr_reg;
    reload_next = reload_reg;
    remain_next = remain_reg;
    words_next = words_reg;
    irq_next = 1'b0;
    req_next = req_reg;
    valid_next = valid_reg;
    data_next = data_reg;
    wb.pop_ready = 1'b0;
    last_word = (remain_reg == 25'h0000001);
    case (state_reg)
      bm_idle: begin
        if (begin_xfer) begin
          // host-supplied address and byte count, in whole words
          base_next = dest_addr;
          addr_next = dest_addr;
          reload_next = byte_count[26:2];
          remain_next = byte_count[26:2];
          words_next = 25'h0000000;
          stop_pend_next = 1'b0;
          // runs on its own; an empty count ends at once
          active_next = (byte_count[26:2] != 25'h0000000);
        end else if (active_reg & stop_pend_reg) begin
          active_next = 1'b0;
          stop_pend_next = 1'b0;
        end else if (active_reg & wb.pop_valid) begin
          // data present again, ask for the bus
          req_next = 1'b1;
          state_next = bm_request;
        end
      end
      bm_request: begin
        if (bm_gnt) begin
          // word taken from the buffer only with the bus in hand
          wb.pop_ready = 1'b1;
          data_next = wb.pop_data;
          valid_next = 1'b1;
          state_next = bm_move;
        end
      end
      bm_move: begin
        // target stall holds address and data
        if (bm_ready) begin
          addr_next = addr_reg + `DIO_WORD_BYTES;
          // words moved, kept after done or stop
          words_next = words_reg + 25'h0000001;
          remain_next = remain_reg - 25'h0000001;
          if (last_word & double_buf) begin
            // circular region: wrap to the start
            addr_next = base_reg;
            remain_next = reload_reg;
          end else if (last_word) begin
            active_next = 1'b0;
            irq_next = irq_enable;
          end
          if (active_next & ~stop_pend_next & wb.pop_valid) begin
            wb.pop_ready = 1'b1;
            data_next = wb.pop_data;
          end else begin
            // buffer empty, block done or stop pending: let go of the bus; only an empty buffer leaves the block running
            valid_next = 1'b0;
            req_next = 1'b0;
            state_next = bm_idle;
            if (stop_pend_next) begin
              active_next = 1'b0;
              stop_pend_next = 1'b0;
            end
          end
        end
      end
      default: begin
        state_next = bm_idle;
        req_next = 1'b0;
        valid_next = 1'b0;
      end
    endcase
  end

  // register stage for all groups
  always_ff @(posedge mclk) begin
    if (srst) begin
      din_word_reg <= 32'h0000_0000;
      in_bit_reg <= 1'b0;
      dout_reg <= 32'h0000_0000;
      pacer_reg <= `DIO_PACER_RST;
      ack_reg <= 1'b0;
      sample_en_reg <= 1'b0;
      overrun_reg <= 1'b0;
      state_reg <= bm_idle;
      active_reg <= 1'b0;
      stop_pend_reg <= 1'b0;
      base_reg <= 32'h0000_0000;
      addr_reg <= 32'h0000_0000;
      reload_reg <= 25'h0000000;
      remain_reg <= 25'h0000000;
      words_reg <= 25'h0000000;
      irq_reg <= 1'b0;
      req_reg <= 1'b0;
      valid_reg <= 1'b0;
      data_reg <= 32'h0000_0000;
    end else begin
      din_word_reg <= din_word_next;
      in_bit_reg <= in_bit_next;
      dout_reg <= dout_next;
      pacer_reg <= pacer_next;
      ack_reg <= ack_next;
      sample_en_reg <= sample_en_next;
      overrun_reg <= overrun_next;
      state_reg <= state_next;
      active_reg <= active_next;
      stop_pend_reg <= stop_pend_next;
      base_reg <= base_next;
      addr_reg <= addr_next;
      reload_reg <= reload_next;
      remain_reg <= remain_next;
      words_reg <= words_next;
      irq_reg <= irq_next;
      req_reg <= req_next;
      valid_reg <= valid_next;
      data_reg <= data_next;
    end
  end

  // outputs straight from flops
  assign input_word = din_word_reg;
  assign input_bit_value = in_bit_reg;
  assign dout_pins = dout_reg;
  assign trig_ack_pin = ack_reg;
  // 1 while running, 0 once done
  assign transfer_active = active_reg;
  assign words_done = words_reg;
  assign done_irq = irq_reg;
  assign overrun = overrun_reg;
  assign bm_req = req_reg;
  assign bm_addr = addr_reg;
  assign bm_data = data_reg;
  assign bm_valid = valid_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_bit_select: assert property (
    in_bit_reg == din_word_reg[$past(input_bit_index)]) else $error("bit read mismatch");
  a_word_out: assert property (
    out_word_wr |=> dout_reg == $past(out_word_data)) else $error("word write lost");
  a_bit_out: assert property (
    out_bit_wr && !out_word_wr |=> dout_reg[$past(output_bit_index)] == $past(out_bit_data))
    else $error("bit write lost");
  a_rise_push: assert property (
    wb.push_valid && sample_mode == sample_mode_rise |-> req_s2_reg && !req_s3_reg)
    else $error("rise sample without edge");
  a_start_runs: assert property (
    start && !active_reg && byte_count[26:2] != 25'h0 |=> active_reg && words_reg == 25'h0)
    else $error("start did not run");
  a_word_step: assert property (
    state_reg == bm_move && bm_ready && !start
    |=> words_reg == $past(words_reg) + 25'h1) else $error("word count step");
  a_release_empty: assert property (
    state_reg == bm_move && bm_ready && !wb.pop_valid |=> !bm_req && !bm_valid)
    else $error("bus held while empty");
  a_stall_hold: assert property (
    bm_valid && !bm_ready |=> $stable(bm_addr) && $stable(bm_data))
    else $error("moved under stall");
  a_done_irq: assert property (
    done_irq |-> !active_reg && $past(active_reg)) else $error("irq without completion");
  a_flush_start: assert property (
    start && !active_reg && clear_fifo_on_start |=> !wb.pop_valid || $past(wb.push_valid))
    else $error("buffer not emptied");
  a_stop_idle: assert property (
    stop_pend_reg && state_reg == bm_idle && !start |=> !active_reg)
    else $error("stop not taken");
  c_done: cover property (active_reg ##1 !active_reg && done_irq);
  c_wrap: cover property (state_reg == bm_move && bm_ready && last_word && double_buf);
  c_rerequest: cover property (!bm_req && active_reg ##[1:20] bm_req);
  c_stop: cover property (stop && state_reg == bm_move);
endmodule

// ===== logic/word_buf.sv
// two-entry word buffer between input sampling and the bus master
`timescale 1ns/1ps
`include "dio_params.svh"
module word_buf (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // both sides of the buffer
  word_buf_if.buf_mp wb
);
  import dio_pkg::*;
  word_t mem_reg [`DIO_BUF_DEPTH];  // storage
  word_t mem_next [`DIO_BUF_DEPTH];
  logic wr_reg, wr_next;           // write slot
  logic rd_reg, rd_next;           // read slot
  logic [1:0] cnt_reg, cnt_next;   // entries held
  logic do_push, do_pop;

  // honest flags: full stalls the handshake sampler and drops paced or edge samples, empty releases the bus
  assign wb.push_ready = (cnt_reg != 2'h2);
  assign wb.pop_valid = (cnt_reg != 2'h0);
  assign wb.pop_data = mem_reg[rd_reg];
  assign do_push = wb.push_valid & wb.push_ready;
  assign do_pop = wb.pop_ready & wb.pop_valid;

  // next pointers and contents; flush wins over both sides
  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (wb.flush) begin
      wr_next = 1'b0;
      rd_next = 1'b0;
      cnt_next = 2'h0;
    end else begin
      if (do_push) begin
        mem_next[wr_reg] = wb.push_data;
        wr_next = ~wr_reg;
      end
      if (do_pop) begin
        rd_next = ~rd_reg;
      end
      cnt_next = cnt_reg + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  // register only
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end
endmodule
